/* File: shared/crtcs_pkg.sv */
package crtcs_pkg;
    // command codes in bits 7:5
    localparam logic [2:0] CMD_RESET   = 3'h0;
    localparam logic [2:0] CMD_START   = 3'h1;
    localparam logic [2:0] CMD_STOP    = 3'h2;
    localparam logic [2:0] CMD_CURSOR  = 3'h4;
    localparam logic [2:0] CMD_IRQ_ON  = 3'h5;
    localparam logic [2:0] CMD_IRQ_OFF = 3'h6;
    localparam logic [2:0] CMD_PRESET  = 3'h7;
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 5;

    // parameter byte counts
    localparam logic [2:0] NPAR_RESET  = 3'h4;
    localparam logic [2:0] NPAR_CURSOR = 3'h2;
    localparam logic [2:0] NPAR_NONE   = 3'h0;

    // status bit positions
    localparam int ST_IE = 6;
    localparam int ST_IR = 5;
    localparam int ST_IC = 3;
    localparam int ST_VE = 2;
    localparam int ST_BU = 1;

    // preset timing in character clocks
    localparam logic [1:0] PRESET_CLKS  = 2'h2;
    localparam logic [1:0] RELEASE_CLKS = 2'h2;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

/* File: rtl/crtcs_edge.sv */
`timescale 1ns/1ps
module crtcs_edge
    import crtcs_pkg::*;
(
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    // level in, pulses out
    input  wire logic level_in,
    output logic      rise_out,
    output logic      fall_out
);
    typedef struct packed
    {
        logic prev;
    } crtcs_edge_s;

    crtcs_edge_s st;
    crtcs_edge_s next_st;

    always_comb
    begin
        next_st.prev = level_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign rise_out = level_in & ~st.prev;
    assign fall_out = ~level_in & st.prev;
endmodule

/* File: rtl/crtcs_top.sv */
`timescale 1ns/1ps
// Summary of operation
// R1: start display enables interrupts, load requests, video; sets irq and video flags.
// R2: stop display turns video off, interrupt enable untouched.
// R3: after stop, retrace outputs keep running; video flag cleared until next start.
// R4: load cursor sends next two parameter bytes to column then row registers.
// R5: enable interrupt sets irq-enable flag and allows requests.
// R6: disable interrupt blocks requests and clears irq-enable flag.
// R7: preset counters holds timing at top-left until another command.
// R8: preset takes two clocks; two more clocks before first character.
// R9: irq-enable gates frame interrupt; set by start, cleared by reset.
// R10: retrace request set at last-row start when enabled; cleared by status read.
// R11: wrong parameter count sets bad-command flag; cleared by status read.
// R12: video flag set by start, cleared by stop and reset.
// R13: row buffer not full at swap sets underrun flag. The code sets it only while loading is on (after start, until reset).
// R14: underrun stops loading and blanks until after next frame retrace.
// R15: load request drops on write strobe fall; loader selects by then.
// R16: port select low writes parameter, high writes command, high read gives status.
// R17: each command takes a fixed zero to four parameter bytes.
// R18: command bits 7:5 decode the seven commands.
// R19: status: bit7 zero, IE6, IR5, IC3, VE2, BU1.
module crtcs_top
    import crtcs_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       arst_n_in,
    // host port, strobes active high, one cycle or longer
    input  wire logic       port_select_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    // buffer loading
    input  wire logic       load_select_n_in,
    output logic            load_request_out,
    // display timing from the raster engine
    input  wire logic       last_row_start_in,
    input  wire logic       swap_in,
    input  wire logic       row_full_in,
    input  wire logic       frame_retrace_in,
    input  wire logic       line_retrace_in,
    // display outputs
    output logic            irq_out,
    output logic            video_blank_out,
    output logic            line_retrace_out,
    output logic            frame_retrace_out,
    output logic            counters_hold_out,
    output logic            first_char_out,
    output logic [7:0]      cursor_col_out,
    output logic [7:0]      cursor_row_out
);
    typedef enum logic [1:0]
    {
        PR_IDLE  = 2'b00,
        PR_LOAD  = 2'b01,
        PR_HOLD  = 2'b10,
        PR_SETUP = 2'b11
    } crtcs_preset_e;

    typedef struct packed
    {
        logic          rst_s1;
        logic          rst_s2;
        logic          irq_enable_flag;
        logic          retrace_request_flag;
        logic          bad_command_flag;
        logic          video_on_flag;
        logic          row_underrun_flag;
        logic          loading;
        logic          underrun_wait;
        logic [2:0]    par_need;
        logic [2:0]    par_got;
        logic [2:0]    cur_cmd;
        crtcs_preset_e pr_state;
        logic [1:0]    pr_cnt;
        logic [7:0]    data_q;
        logic          load_request;
        logic          irq;
        logic          blank;
        logic          line_rt;
        logic          frame_rt;
        logic          first_char;
        logic          hold;
        logic [7:0]    cursor_col;
        logic [7:0]    cursor_row;
    } crtcs_s;

    crtcs_s st;
    crtcs_s next_st;
    logic   rst_n;
    logic   wr_rise;
    logic   rd_fall;
    logic   ld_fall;
    logic   frame_fall;
    logic   unused_rise;

    assign rst_n = st.rst_s2;

    crtcs_edge u_wr_edge
    (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n),
        .level_in (wr_in),
        .rise_out (wr_rise),
        .fall_out ()
    );

    // status read effects taken at end of read
    crtcs_edge u_rd_edge
    (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n),
        .level_in (rd_in & port_select_in),
        .rise_out (),
        .fall_out (rd_fall)
    );

    crtcs_edge u_ld_edge
    (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n),
        .level_in (wr_in & ~load_select_n_in),
        .rise_out (unused_rise),
        .fall_out ()
    );

    crtcs_edge u_fr_edge
    (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n),
        .level_in (frame_retrace_in),
        .rise_out (),
        .fall_out (frame_fall)
    );

    // a write strobe "falls" when asserted, matching an active-low pin
    assign ld_fall = unused_rise;

    always_comb
    begin
        logic       cmd_wr;
        logic       par_wr;
        logic [2:0] code;
        logic       set_ir;
        logic       set_bu;
        // loader writes with select low go to the row buffer, not to the host registers
        cmd_wr = wr_rise & port_select_in & load_select_n_in; // R16
        par_wr = wr_rise & ~port_select_in & load_select_n_in; // R16
        code = data_in[CMD_MSB:CMD_LSB];
        set_ir = last_row_start_in & st.irq_enable_flag; // R10
        set_bu = swap_in & ~row_full_in & st.loading; // R13
        next_st = st;
        next_st.rst_s1 = 1'b1;
        next_st.rst_s2 = st.rst_s1;

        // clear on read first, so a same-cycle set wins
        if (rd_fall)
        begin
            next_st.retrace_request_flag = 1'b0; // R10
            next_st.bad_command_flag = 1'b0; // R11
        end

        if (par_wr)
        begin
            if (st.par_got >= st.par_need)
                next_st.bad_command_flag = 1'b1; // R11
            else
                next_st.par_got = st.par_got + 3'h1;
            if (st.cur_cmd == CMD_CURSOR && st.par_got == 3'h0)
                next_st.cursor_col = data_in; // R4
            if (st.cur_cmd == CMD_CURSOR && st.par_got == 3'h1)
                next_st.cursor_row = data_in; // R4
        end

        if (cmd_wr)
        begin
            if (st.par_got != st.par_need)
                next_st.bad_command_flag = 1'b1; // R11 R17
            next_st.cur_cmd = code;
            next_st.par_got = 3'h0;
            next_st.par_need = NPAR_NONE;
            if (st.pr_state != PR_IDLE)
                next_st.pr_state = PR_SETUP; // R7
            next_st.pr_cnt = '0;
            unique case (code) // R18
                CMD_RESET:
                begin
                    next_st.par_need = NPAR_RESET; // R17
                    next_st.irq_enable_flag = 1'b0; // R9
                    next_st.video_on_flag = 1'b0; // R12
                    next_st.loading = 1'b0;
                end
                CMD_START:
                begin
                    next_st.irq_enable_flag = 1'b1; // R1 R9
                    next_st.video_on_flag = 1'b1; // R1 R12
                    next_st.loading = 1'b1; // R1
                end
                CMD_STOP:
                    next_st.video_on_flag = 1'b0; // R2 R3
                CMD_CURSOR:
                    next_st.par_need = NPAR_CURSOR; // R4
                CMD_IRQ_ON:
                    next_st.irq_enable_flag = 1'b1; // R5
                CMD_IRQ_OFF:
                    next_st.irq_enable_flag = 1'b0; // R6
                CMD_PRESET:
                begin
                    next_st.pr_state = PR_LOAD; // R7
                end
                default:
                    next_st.cur_cmd = code; // code 3 is unused, ignored
            endcase
        end

        if (set_ir)
            next_st.retrace_request_flag = 1'b1; // R10
        if (cmd_wr && code == CMD_START)
            next_st.row_underrun_flag = 1'b0;
        if (set_bu)
        begin
            next_st.row_underrun_flag = 1'b1; // R13
            next_st.underrun_wait = 1'b1; // R14
        end
        // resume once the following frame retrace ends
        if (st.underrun_wait && frame_fall && !set_bu)
            next_st.underrun_wait = 1'b0; // R14

        // preset sequencer, two clocks to load, two before first character
        next_st.first_char = 1'b0;
        unique case (st.pr_state)
            PR_IDLE:
                next_st.pr_cnt = '0;
            PR_LOAD:
            begin
                next_st.pr_cnt = st.pr_cnt + 2'h1;
                if (st.pr_cnt + 2'h1 == PRESET_CLKS && !cmd_wr)
                    next_st.pr_state = PR_HOLD; // R8
            end
            PR_HOLD:
                next_st.pr_cnt = '0; // R7
            PR_SETUP:
            begin
                next_st.pr_cnt = st.pr_cnt + 2'h1;
                if (st.pr_cnt + 2'h1 == RELEASE_CLKS)
                begin
                    next_st.pr_state = PR_IDLE;
                    next_st.first_char = 1'b1; // R8
                end
            end
        endcase

        next_st.hold = (next_st.pr_state == PR_LOAD) | (next_st.pr_state == PR_HOLD); // R7
        // load request drops on strobe, re-arms at strobe end
        if (ld_fall)
            next_st.load_request = 1'b0; // R15
        else
            next_st.load_request = next_st.loading & ~next_st.underrun_wait & ~wr_in; // R1 R14
        next_st.irq = next_st.retrace_request_flag & next_st.irq_enable_flag; // R5 R6 R9
        next_st.blank = ~next_st.video_on_flag | next_st.underrun_wait; // R2 R14
        next_st.line_rt = line_retrace_in; // R3
        next_st.frame_rt = frame_retrace_in; // R3

        next_st.data_q = BYTE_ZERO; // R19
        next_st.data_q[ST_IE] = next_st.irq_enable_flag;
        next_st.data_q[ST_IR] = next_st.retrace_request_flag;
        next_st.data_q[ST_IC] = next_st.bad_command_flag;
        next_st.data_q[ST_VE] = next_st.video_on_flag;
        next_st.data_q[ST_BU] = next_st.row_underrun_flag;
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st <= '0;
            st.blank <= 1'b1;
        end
        else if (!st.rst_s2)
        begin
            st <= '0;
            st.rst_s1 <= 1'b1;
            st.rst_s2 <= st.rst_s1;
            st.blank <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign data_out          = st.data_q;
    assign load_request_out  = st.load_request;
    assign irq_out           = st.irq;
    assign video_blank_out   = st.blank;
    assign line_retrace_out  = st.line_rt;
    assign frame_retrace_out = st.frame_rt;
    assign counters_hold_out = st.hold;
    assign first_char_out    = st.first_char;
    assign cursor_col_out    = st.cursor_col;
    assign cursor_row_out    = st.cursor_row;
endmodule

/* File: verification/crtcs_asserts.sv */
`timescale 1ns/1ps
module crtcs_asserts
    import crtcs_pkg::*;
(
    // clock and reset
    input wire logic       mclk_in,
    input wire logic       arst_n_in,
    // watched ports
    input wire logic       port_select_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic       load_select_n_in,
    input wire logic       load_request_out,
    input wire logic       last_row_start_in,
    input wire logic       swap_in,
    input wire logic       row_full_in,
    input wire logic       irq_out,
    input wire logic       video_blank_out,
    input wire logic       counters_hold_out,
    input wire logic       first_char_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_cmd(logic [2:0] c);
        $rose(wr_in) && port_select_in && load_select_n_in && data_in[7:5] == c;
    endsequence

    AST_MSB_ZERO: assert property (data_out[7] == 1'b0)
        else $error("status msb high");
    AST_START: assert property (s_cmd(CMD_START) |-> ##[1:3] (data_out[ST_IE] && data_out[ST_VE] && !video_blank_out))
        else $error("start not applied");
    AST_STOP: assert property (s_cmd(CMD_STOP) |-> ##[1:3] (!data_out[ST_VE] && video_blank_out))
        else $error("stop not applied");
    AST_STOP_IE: assert property (s_cmd(CMD_STOP) ##0 data_out[ST_IE] |-> ##3 data_out[ST_IE])
        else $error("stop touched irq enable");
    AST_IRQ_ON: assert property (s_cmd(CMD_IRQ_ON) |-> ##[1:3] data_out[ST_IE])
        else $error("irq enable not set");
    AST_RESET_CMD: assert property (s_cmd(CMD_RESET) |-> ##[1:3] !(data_out[ST_VE] || data_out[ST_IE]))
        else $error("reset kept flags");
    AST_IR_SET: assert property (last_row_start_in && data_out[ST_IE] |-> ##[1:3] (data_out[ST_IR] && irq_out))
        else $error("retrace request missing");
    AST_IR_GATED: assert property (last_row_start_in && !data_out[ST_IE] && !data_out[ST_IR] |-> ##2 !data_out[ST_IR])
        else $error("request while disabled");
    AST_READ_CLR: assert property ($fell(rd_in && port_select_in) |-> ##[1:2] !(data_out[ST_IR] || data_out[ST_IC]))
        else $error("read left flags");
    AST_PRESET: assert property (s_cmd(CMD_PRESET) |-> ##[1:2] counters_hold_out [*3])
        else $error("preset hold missing");
    AST_FIRST: assert property ($fell(counters_hold_out) |-> ##2 first_char_out)
        else $error("first char late");
    AST_LOAD_DROP: assert property ($rose(wr_in) && !load_select_n_in && load_request_out |-> ##[1:2] !load_request_out)
        else $error("request not withdrawn");
    AST_UNDERRUN: assert property (swap_in && !row_full_in && load_request_out |-> ##[1:2] (data_out[ST_BU] && video_blank_out))
        else $error("underrun missed");
endmodule

/* File: verification/crtcs_loader_model.sv */
`timescale 1ns/1ps
module crtcs_loader_model (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    // bench control
    input  wire logic run_in,
    input  wire logic slow_in,
    // handshake
    input  wire logic load_request_in,
    output logic      load_select_n_out,
    output logic      wr_out
);
    task automatic tick();
        @(negedge mclk_in);
    endtask

    // select released goes to its pull-up level; request looked at once settled
    always
    begin
        load_select_n_out = 1'b1;
        wr_out = 1'b0;
        @(posedge mclk_in);
        #1;
        if (arst_n_in && run_in && load_request_in)
        begin
            tick();
            load_select_n_out = 1'b0;
            if (slow_in)
                tick();
            tick();
            wr_out = 1'b1;
            tick();
            wr_out = 1'b0;
            tick();
        end
    end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) bad(n, e, g); end
module tb;
    import crtcs_pkg::*;
    logic       mclk_in, arst_n_in, port_select_in, host_wr, rd_in, last_row_start_in, swap_in, row_full_in;
    logic       frame_retrace_in, line_retrace_in, run, slow, load_select_n_in, load_request_out, irq_out;
    logic       video_blank_out, line_retrace_out, counters_hold_out, first_char_out, dma_wr, wr_in;
    logic       frame_retrace_out;
    logic [7:0] data_in, data_out, cursor_col_out, cursor_row_out, st;
    int         errors, tests_run, cyc;

    assign wr_in = host_wr | dma_wr;
    crtcs_top u_dut (.mclk_in, .arst_n_in, .port_select_in, .wr_in, .rd_in, .data_in, .data_out, .load_select_n_in,
        .load_request_out, .last_row_start_in, .swap_in, .row_full_in, .frame_retrace_in, .line_retrace_in, .irq_out,
        .video_blank_out, .line_retrace_out, .frame_retrace_out, .counters_hold_out, .first_char_out,
        .cursor_col_out, .cursor_row_out);
    crtcs_loader_model u_loader (.mclk_in, .arst_n_in, .run_in(run), .slow_in(slow),
        .load_request_in(load_request_out), .load_select_n_out(load_select_n_in), .wr_out(dma_wr));

    task automatic bad(input string n, input logic [7:0] e, input logic [7:0] g);
        errors++;
        $display("BAD %s exp %h got %h", n, e, g);
    endtask
    task automatic nw(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic wb(input logic ps, input logic [7:0] d);
        port_select_in = ps;
        data_in = d;
        host_wr = 1'b1;
        nw(1);
        host_wr = 1'b0;
        nw(3);
    endtask
    task automatic rs();
        port_select_in = 1'b1;
        rd_in = 1'b1;
        nw(1);
        st = data_out;
        rd_in = 1'b0;
        nw(3);
    endtask
    task automatic pulse(input bit row);
        last_row_start_in = row;
        swap_in = !row;
        nw(1);
        last_row_start_in = 1'b0;
        swap_in = 1'b0;
        nw(3);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_display();
        wb(1, 8'h20);
        `CHK("start", 8'h44, data_out & 8'hc6)
        `CHK("request", 8'h01, load_request_out)
        wb(1, 8'h40);
        `CHK("stop", 8'h40, data_out & 8'hc4)
        `CHK("blank", 8'h01, video_blank_out)
        line_retrace_in = 1'b1;
        nw(3);
        `CHK("line", 8'h01, line_retrace_out)
        line_retrace_in = 1'b0;
    endtask
    task automatic t_irq();
        wb(1, 8'hc0);
        pulse(1);
        `CHK("gated", 8'h00, data_out & 8'h60)
        wb(1, 8'ha0);
        pulse(1);
        `CHK("ir", 8'h60, data_out & 8'h60)
        `CHK("irq", 8'h01, irq_out)
        rs();
        `CHK("read", 8'h60, st & 8'he0)
        `CHK("ir clr", 8'h40, data_out & 8'h60)
    endtask
    task automatic t_cursor();
        wb(1, 8'h80);
        wb(0, 8'h12);
        wb(0, 8'h34);
        `CHK("col", 8'h12, cursor_col_out)
        `CHK("row", 8'h34, cursor_row_out)
        `CHK("flags", 8'h40, data_out & 8'h6e)
        wb(0, 8'h56);
        `CHK("extra", 8'h08, data_out & 8'h08)
        `CHK("col kept", 8'h12, cursor_col_out)
        rs();
        `CHK("ic clr", 8'h00, data_out & 8'h08)
        wb(1, 8'h80);
        wb(0, 8'h77);
        wb(1, 8'ha0);
        `CHK("short", 8'h08, data_out & 8'h08)
        rs();
        wb(1, 8'h20);
        wb(1, 8'h00);
        for (int i = 0; i < 4; i++)
            wb(0, 8'h4f);
        `CHK("reset", 8'h00, data_out & 8'h4c)
        `CHK("reset blank", 8'h01, video_blank_out)
        `CHK("reset req", 8'h00, load_request_out)
    endtask
    task automatic t_preset();
        wb(1, 8'he0);
        nw(4);
        `CHK("hold", 8'h01, counters_hold_out)
        data_in = 8'ha0;
        host_wr = 1'b1;
        nw(1);
        host_wr = 1'b0;
        nw(1);
        `CHK("not yet", 8'h00, first_char_out)
        nw(1);
        `CHK("first", 8'h01, first_char_out)
        `CHK("free", 8'h00, counters_hold_out)
        nw(3);
    endtask
    task automatic t_load();
        wb(1, 8'h20);
        port_select_in = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            slow = s[0];
            run = 1'b1;
            for (int k = 0; k < 20 && dma_wr !== 1'b1; k++)
                @(posedge mclk_in);
            nw(1);
            `CHK("drop", 8'h00, load_request_out)
            `CHK("no param", 8'h00, data_out & 8'h08)
            run = 1'b0;
            nw(6);
        end
        wb(1, 8'h20);
        row_full_in = 1'b1;
        pulse(0);
        `CHK("full", 8'h00, data_out & 8'h02)
        row_full_in = 1'b0;
        pulse(0);
        `CHK("under", 8'h02, data_out & 8'h02)
        `CHK("u blank", 8'h01, video_blank_out)
        `CHK("u stop", 8'h00, load_request_out)
        frame_retrace_in = 1'b1;
        nw(4);
        `CHK("in vr", 8'h01, video_blank_out)
        `CHK("frame", 8'h01, frame_retrace_out)
        frame_retrace_in = 1'b0;
        nw(4);
        `CHK("after vr", 8'h00, video_blank_out)
    endtask

    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            end_of_test();
        end
    end
    initial
    begin
        {arst_n_in, port_select_in, host_wr, rd_in, last_row_start_in, swap_in, row_full_in} = '0;
        {frame_retrace_in, line_retrace_in, run, slow} = '0;
        data_in = 8'h00;
        nw(8);
        `CHK("rst blank", 8'h01, video_blank_out)
        arst_n_in = 1'b1;
        nw(4);
        t_display();
        t_irq();
        t_cursor();
        t_preset();
        t_load();
        end_of_test();
    end
endmodule

bind crtcs_top crtcs_asserts u_chk (.mclk_in, .arst_n_in, .port_select_in, .wr_in, .rd_in, .data_in, .data_out,
    .load_select_n_in, .load_request_out, .last_row_start_in, .swap_in, .row_full_in, .irq_out, .video_blank_out,
    .counters_hold_out, .first_char_out);
